// ===== adsc_pkg.sv
/*
 * Shared constants for the converter sequencer: register map, field
 * positions, reset values, event bit order, timing and sequencer states.
 * Assumes a 10 MHz system clock and a 16-bit byte address decode.
 */
package adsc_pkg;
    // Register byte addresses.
    localparam logic [15:0] CFG_ADDR = 16'hd004;
    localparam logic [15:0] OFFS_ADDR = 16'hd008;
    localparam logic [15:0] GAIN_ADDR = 16'hd00c;
    localparam logic [15:0] FLAG_ADDR = 16'ha810;
    localparam logic [15:0] EVEN_ADDR = 16'ha850;
    // Reset values.
    localparam logic [15:0] CFG_RESET = 16'h1800;
    localparam logic [15:0] OFFS_RESET = 16'h0000;
    localparam logic [15:0] GAIN_RESET = 16'h8000;
    // Configuration fields; bit 1 is reserved and never stored.
    localparam int EN_BIT = 0;
    localparam int CLKSEL_BIT = 2;
    localparam int NMUX_LSB = 3;
    localparam int PMUX_LSB = 7;
    localparam int NRANGE_BIT = 11;
    localparam int PRANGE_BIT = 12;
    localparam int PERIOD_LSB = 13;
    localparam logic [15:0] CFG_WMASK = 16'hfffd;
    // Event flags sit at bits 4:1 of the flag and enable registers.
    localparam int EVT_LSB = 1;
    localparam int EVT_N = 4;
    localparam int EVT_HALF = 0;
    localparam int EVT_FULL = 1;
    localparam int EVT_SAT = 2;
    localparam int EVT_OVF = 3;
    // Sample period and resolution.
    localparam int BASE_CLOCKS = 32;
    localparam int MAX_UNUSED = 11;
    // Timing: rates in MHz, settling in ns and in sampling clocks of each rate.
    localparam int SYS_CLK_MHZ = 10;
    localparam int FAST_MHZ = 6;
    localparam int SLOW_MHZ = 1;
    localparam int SETTLE_NS = 21000;
    localparam int SETTLE_TICKS_FAST = (SETTLE_NS * FAST_MHZ + 999) / 1000;
    localparam int SETTLE_TICKS_SLOW = (SETTLE_NS * SLOW_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        SEQ_OFF = 2'b00,
        SEQ_SETTLE = 2'b01,
        SEQ_CONVERT = 2'b10
    } adsc_seq_e;
endpackage : adsc_pkg

// ===== adsc_evt_if.sv
/*
 * Carrier between the sequencer and the event flag keeper: event set
 * pulses, write-one-to-clear mask, enable register write and the state.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface adsc_evt_if;
    logic [3:0] set;
    logic [3:0] clr;
    logic en_wr;
    logic [3:0] en_wdata;
    logic [3:0] flags;
    logic [3:0] enables;
    modport src (output set, output clr, output en_wr, output en_wdata,
                 input flags, input enables);
    modport keeper (input set, input clr, input en_wr, input en_wdata,
                    output flags, output enables);
endinterface : adsc_evt_if
`default_nettype wire

// ===== adsc_rate_gen.sv
/*
 * Sampling clock enable: a one-cycle pulse at 6 MHz or 1 MHz on average,
 * made from the system clock by a fractional accumulator.
 * Assumes the system clock is at least as fast as the fast rate.
 */
`timescale 1ns/1ps
`default_nettype none
module adsc_rate_gen #(
    parameter int SYS_MHZ = adsc_pkg::SYS_CLK_MHZ
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Rate select and enable out
    input wire logic i_slow_sel,
    output var logic o_tick
);
    import adsc_pkg::*;

    if (SYS_MHZ < FAST_MHZ || SYS_MHZ > 255) begin : g_chk
        $error("adsc_rate_gen: system clock cannot serve the fast rate");
    end

    logic [7:0] acc_q, acc_d;
    logic tick_d;
    logic [8:0] sum;

    // Uneven spacing at 6 MHz is traded for needing no second clock.
    always_comb begin
        sum = {1'b0, acc_q} + (i_slow_sel ? 9'(SLOW_MHZ) : 9'(FAST_MHZ));
        tick_d = sum >= 9'(SYS_MHZ);
        acc_d = tick_d ? 8'(sum - 9'(SYS_MHZ)) : sum[7:0];
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            acc_q <= 8'h00;
            o_tick <= 1'b0;
        end else begin
            acc_q <= acc_d;
            o_tick <= tick_d;
        end
    end
endmodule : adsc_rate_gen
`default_nettype wire

// ===== adsc_event_flags.sv
/*
 * Sticky event flags with write-one-to-clear, enable mask and the
 * registered interrupt request.
 * Assumes set and clear pulses arrive on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module adsc_event_flags (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Event carrier
    adsc_evt_if.keeper ev,
    // Interrupt request
    output var logic o_irq
);
    import adsc_pkg::*;

    logic [3:0] flags_q, flags_d, en_q, en_d;
    logic irq_d;

    always_comb begin
        // A set in the clearing cycle wins, so no event is lost.
        flags_d = (flags_q & ~ev.clr) | ev.set;
        en_d = ev.en_wr ? ev.en_wdata : en_q;
        irq_d = |(flags_d & en_d);
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            flags_q <= 4'h0;
            en_q <= 4'h0;
            o_irq <= 1'b0;
        end else begin
            flags_q <= flags_d;
            en_q <= en_d;
            o_irq <= irq_d;
        end
    end

    assign ev.flags = flags_q;
    assign ev.enables = en_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    w1c_clear_a: assert property ((ev.clr & ~ev.set) != 4'h0 |=>
        (flags_q & $past(ev.clr & ~ev.set)) == 4'h0) else $error("flag not cleared");
    zero_keeps_a: assert property ((ev.set == 4'h0) |=>
        flags_q == ($past(flags_q) & ~$past(ev.clr))) else $error("flag changed");
    irq_gate_a: assert property (o_irq == |(flags_q & en_q))
        else $error("irq not flag and enable");
    set_unmasked_a: assert property (ev.set != 4'h0 |=>
        (flags_q & $past(ev.set)) == $past(ev.set)) else $error("set lost");
    irq_seen_c: cover property (o_irq ##1 !o_irq);
endmodule : adsc_event_flags
`default_nettype wire

// ===== adsc_top.sv
/*
 * Converter sequencer control: AHB-Lite register slave, configuration,
 * startup settling, discard of the first conversion, gain correction
 * with clamping, result delivery to the sample DMA and event flags.
 * Assumes core data, DMA status and clock switch pulses share i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module adsc_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output var logic [31:0] o_hrdata,
    output var logic o_hreadyout,
    output var logic o_hresp,
    // Converter core
    input wire logic [15:0] i_core_data,
    input wire logic i_clk_src_switch,
    output var logic o_core_enable,
    output var logic o_sample_tick,
    output var logic [3:0] o_pos_input_sel,
    output var logic [3:0] o_neg_input_sel,
    output var logic o_pos_high_range,
    output var logic o_neg_high_range,
    output var logic o_slow_sample_clk_sel,
    output var logic o_input_reserved,
    // Sample DMA channel
    input wire logic i_dma_active,
    input wire logic i_dma_store,
    input wire logic i_dma_last,
    input wire logic i_dma_half_last,
    output var logic o_result_valid,
    output var logic [15:0] o_result_data,
    // Interrupt request
    output var logic o_irq
);
    import adsc_pkg::*;

    adsc_evt_if ev ();

    adsc_event_flags u_flags (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .ev(ev),
        .o_irq(o_irq)
    );

    adsc_rate_gen #(.SYS_MHZ(SYS_CLK_MHZ)) u_rate (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_slow_sel(o_slow_sample_clk_sel),
        .o_tick(o_sample_tick)
    );

    // Bus state.
    logic dp_valid_q, dp_valid_d, dp_write_q, dp_write_d;
    logic [15:0] dp_addr_q, dp_addr_d;
    logic [31:0] rdata_d, rmux;
    logic take;
    // Register state.
    logic [15:0] cfg_q, cfg_d, offs_q, offs_d, gain_q, gain_d;
    logic cfg_wr;
    logic pos_res, neg_res;
    // Sequencer state.
    adsc_seq_e seq_q, seq_d;
    logic [12:0] cnt_q, cnt_d, period, settle_lim;
    logic discard_q, discard_d, deliver, restart, en;
    logic res_valid_d;
    logic [15:0] res_data_d, mask, masked;
    logic [16:0] sum;
    logic signed [33:0] prod, scaled;
    logic sat;
    logic [2:0] code;

    function automatic logic mux_reserved(input logic [3:0] sel);
        // Pins 0..5, ground, half reference, reference, half regulator.
        mux_reserved = (sel > 4'h5 && sel < 4'h8) || sel > 4'hb;
    endfunction

    // AHB-Lite: zero wait states, OKAY always, unmapped reads give zero.
    always_comb begin
        take = i_hsel && i_htrans[1] && i_hready;
        dp_valid_d = take;
        dp_write_d = take && i_hwrite;
        dp_addr_d = take ? i_haddr[15:0] : dp_addr_q;
        case (i_haddr[15:0])
            CFG_ADDR: rmux = {16'h0000, cfg_q};
            OFFS_ADDR: rmux = {16'h0000, offs_q};
            GAIN_ADDR: rmux = {16'h0000, gain_q};
            FLAG_ADDR: rmux = {27'h0000000, ev.flags, 1'b0};
            EVEN_ADDR: rmux = {27'h0000000, ev.enables, 1'b0};
            default: rmux = 32'h00000000;
        endcase
        rdata_d = (take && !i_hwrite) ? rmux : o_hrdata;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 16'h0000;
            o_hrdata <= 32'h00000000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            dp_valid_q <= dp_valid_d;
            dp_write_q <= dp_write_d;
            dp_addr_q <= dp_addr_d;
            o_hrdata <= rdata_d;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // Register writes land in the data phase.
    always_comb begin
        cfg_wr = dp_valid_q && dp_write_q && dp_addr_q == CFG_ADDR;
        // Reserved bit 1 is dropped, so a careless write does no harm.
        cfg_d = cfg_wr ? (i_hwdata[15:0] & CFG_WMASK) : cfg_q;
        offs_d = (dp_valid_q && dp_write_q && dp_addr_q == OFFS_ADDR) ?
            i_hwdata[15:0] : offs_q;
        gain_d = (dp_valid_q && dp_write_q && dp_addr_q == GAIN_ADDR) ?
            i_hwdata[15:0] : gain_q;
        ev.clr = (dp_valid_q && dp_write_q && dp_addr_q == FLAG_ADDR) ?
            i_hwdata[EVT_LSB +: EVT_N] : 4'h0;
        ev.en_wr = dp_valid_q && dp_write_q && dp_addr_q == EVEN_ADDR;
        ev.en_wdata = i_hwdata[EVT_LSB +: EVT_N];
        pos_res = mux_reserved(cfg_d[PMUX_LSB +: 4]);
        neg_res = mux_reserved(cfg_d[NMUX_LSB +: 4]);
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cfg_q <= CFG_RESET;
            offs_q <= OFFS_RESET;
            gain_q <= GAIN_RESET;
            o_pos_input_sel <= CFG_RESET[PMUX_LSB +: 4];
            o_neg_input_sel <= CFG_RESET[NMUX_LSB +: 4];
            o_pos_high_range <= CFG_RESET[PRANGE_BIT];
            o_neg_high_range <= CFG_RESET[NRANGE_BIT];
            o_slow_sample_clk_sel <= CFG_RESET[CLKSEL_BIT];
            o_input_reserved <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            offs_q <= offs_d;
            gain_q <= gain_d;
            o_pos_input_sel <= cfg_d[PMUX_LSB +: 4];
            o_neg_input_sel <= cfg_d[NMUX_LSB +: 4];
            o_pos_high_range <= cfg_d[PRANGE_BIT];
            o_neg_high_range <= cfg_d[NRANGE_BIT];
            o_slow_sample_clk_sel <= cfg_d[CLKSEL_BIT];
            o_input_reserved <= pos_res || neg_res;
        end
    end

    // Gain correction on the left-aligned result.
    always_comb begin
        code = cfg_q[PERIOD_LSB +: 3];
        mask = 16'hffff << (4'(MAX_UNUSED) - {1'b0, code});
        masked = i_core_data & mask;
        sum = {masked[15], masked} + {offs_q[15], offs_q};
        prod = $signed({{17{sum[16]}}, sum}) * $signed({18'h00000, gain_q});
        scaled = prod >>> 15;
        sat = 1'b0;
        if (scaled > 34'sd32767) begin
            res_data_d = 16'h7fff;
            sat = 1'b1;
        end else if (scaled < -34'sd32768) begin
            res_data_d = 16'h8000;
            sat = 1'b1;
        end else begin
            res_data_d = scaled[15:0];
        end
    end

    // Sequencer: off, analog settling, continuous conversion.
    always_comb begin
        en = cfg_q[EN_BIT];
        period = 13'(BASE_CLOCKS) << code;
        settle_lim = o_slow_sample_clk_sel ? 13'(SETTLE_TICKS_SLOW) :
            13'(SETTLE_TICKS_FAST);
        restart = cfg_wr || i_clk_src_switch;
        seq_d = seq_q;
        cnt_d = cnt_q;
        discard_d = discard_q;
        deliver = 1'b0;
        case (seq_q)
            SEQ_OFF: begin
                if (en) begin
                    seq_d = SEQ_SETTLE;
                    cnt_d = 13'h0000;
                end
            end
            SEQ_SETTLE: begin
                if (!en) begin
                    seq_d = SEQ_OFF;
                end else if (o_sample_tick) begin
                    if (cnt_q == settle_lim - 13'h0001) begin
                        seq_d = SEQ_CONVERT;
                        cnt_d = 13'h0000;
                        discard_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 13'h0001;
                    end
                end
            end
            SEQ_CONVERT: begin
                if (!en) begin
                    seq_d = SEQ_OFF;
                end else if (restart) begin
                    // The conversion under way mixes settings, so drop it.
                    cnt_d = 13'h0000;
                    discard_d = 1'b1;
                end else if (o_sample_tick) begin
                    if (cnt_q == period - 13'h0001) begin
                        cnt_d = 13'h0000;
                        discard_d = 1'b0;
                        deliver = !discard_q;
                    end else begin
                        cnt_d = cnt_q + 13'h0001;
                    end
                end
            end
            default: begin
                seq_d = SEQ_OFF;
                cnt_d = 13'h0000;
            end
        endcase
        res_valid_d = deliver;
        // Delivery ignores DMA state; a write never stalls the DMA side.
        ev.set[EVT_OVF] = deliver && !i_dma_active;
        ev.set[EVT_SAT] = deliver && sat;
        ev.set[EVT_FULL] = i_dma_store && i_dma_last;
        ev.set[EVT_HALF] = i_dma_store && i_dma_half_last;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            seq_q <= SEQ_OFF;
            cnt_q <= 13'h0000;
            discard_q <= 1'b0;
            o_result_valid <= 1'b0;
            o_result_data <= 16'h0000;
            o_core_enable <= 1'b0;
        end else begin
            seq_q <= seq_d;
            cnt_q <= cnt_d;
            discard_q <= discard_d;
            o_result_valid <= res_valid_d;
            o_result_data <= deliver ? res_data_d : o_result_data;
            o_core_enable <= seq_d != SEQ_OFF;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    halt_on_clear_a: assert property (!en |=> seq_q == SEQ_OFF && !o_core_enable)
        else $error("not halted");
    settle_end_a: assert property (seq_q == SEQ_SETTLE && en && o_sample_tick &&
        cnt_q == settle_lim - 13'h0001 |=> seq_q == SEQ_CONVERT && discard_q)
        else $error("settle end wrong");
    settle_start_a: assert property (seq_q == SEQ_OFF && en |=>
        seq_q == SEQ_SETTLE && cnt_q == 13'h0000) else $error("no settle");
    write_rearm_a: assert property (seq_q == SEQ_CONVERT && en && cfg_wr |=>
        discard_q && cnt_q == 13'h0000) else $error("discard not re-armed");
    switch_rearm_a: assert property (seq_q == SEQ_CONVERT && en &&
        i_clk_src_switch |=> discard_q) else $error("switch ignored");
    drop_first_a: assert property (seq_q == SEQ_CONVERT && discard_q && en && !restart &&
        o_sample_tick && cnt_q == period - 13'h0001 |=> !o_result_valid && !discard_q)
        else $error("first kept");
    overflow_set_a: assert property (deliver && !i_dma_active |=>
        o_result_valid ##1 ev.flags[EVT_OVF]) else $error("overflow missed");
    sat_clamp_a: assert property (deliver && sat |=>
        (o_result_data == 16'h7fff || o_result_data == 16'h8000) ##1 ev.flags[EVT_SAT])
        else $error("clamp wrong");
    full_set_a: assert property (i_dma_store && i_dma_last |=>
        ev.flags[EVT_FULL]) else $error("full flag missed");
    half_set_a: assert property (i_dma_store && i_dma_half_last |=>
        ev.flags[EVT_HALF]) else $error("half flag missed");
    period_bound_a: assert property (seq_q == SEQ_CONVERT |-> cnt_q < period)
        else $error("period overrun");

    settle_done_c: cover property (seq_q == SEQ_SETTLE ##1 seq_q == SEQ_CONVERT);
    result_c: cover property (o_result_valid && i_dma_active);
    sat_c: cover property (deliver && sat);
    restart_c: cover property (seq_q == SEQ_CONVERT && cfg_wr && en);
endmodule : adsc_top
`default_nettype wire

// ===== adsc_dma_model.sv
/*
 * Sample DMA channel model in auto wrap mode: stores each delivered result
 * one cycle later while running and marks the half and last locations.
 * Assumes results arrive as one-cycle pulses on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module adsc_dma_model #(
    parameter int SIZE = 2
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Control and results
    input wire logic i_run,
    input wire logic i_result_valid,
    // Channel status
    output var logic o_active,
    output var logic o_store,
    output var logic o_last,
    output var logic o_half_last
);
    int cnt = 0;
    logic hit;
    assign hit = o_active && i_result_valid;
    // Stopping the channel also resets its pointer, as a DMA reset would.
    always @(posedge i_clk) begin
        o_active <= i_reset_n && i_run;
        o_store <= hit;
        o_last <= hit && cnt == SIZE - 1;
        o_half_last <= hit && cnt == SIZE / 2 - 1;
        if (!o_active) begin
            cnt <= 0;
        end else if (hit) begin
            cnt <= (cnt == SIZE - 1) ? 0 : cnt + 1;
        end
    end
endmodule : adsc_dma_model
`default_nettype wire

// ===== tb_top.sv
/*
 * Self-checking bench for the converter sequencer: AHB-Lite register access,
 * output decode, sequencing times, results and event flags.
 * Assumes the DMA model above and a 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import adsc_pkg::*;
    logic i_clk = 0, i_reset_n = 0, hsel = 0, hwrite = 0, sw = 0, run = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, v;
    logic [1:0] htrans = 0;
    logic [15:0] raw = 0, rdata, rres;
    logic [3:0] psel, nsel;
    logic hready, hresp, core_en, tick, ph, nh, slow, resv, act, store, last, half, rvalid, irq;
    int bad_count = 0, check_count = 0, n, cyc, carry = 0;
    always #50 i_clk = ~i_clk;
    adsc_top adsc_top_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_core_data(raw), .i_clk_src_switch(sw), .o_core_enable(core_en),
        .o_sample_tick(tick), .o_pos_input_sel(psel), .o_neg_input_sel(nsel),
        .o_pos_high_range(ph), .o_neg_high_range(nh), .o_slow_sample_clk_sel(slow),
        .o_input_reserved(resv), .i_dma_active(act), .i_dma_store(store), .i_dma_last(last),
        .i_dma_half_last(half), .o_result_valid(rvalid), .o_result_data(rres), .o_irq(irq));
    adsc_dma_model adsc_dma_model_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_run(run),
        .i_result_valid(rvalid), .o_active(act), .o_store(store), .o_last(last),
        .o_half_last(half));
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task xfer(input logic w, input logic [15:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {16'h0000, a};
        hwrite <= w;
        do @(posedge i_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        rd = hrdata;
        check("resp", hresp, 32'h0);
    endtask : xfer
    // Counts sample ticks up to the next delivered result. The tick seen
    // together with the result already belongs to the next period, so it
    // is carried over instead of counted.
    task wres(input bit keep);
        n = keep ? carry : 0;
        cyc = 0;
        do begin
            @(posedge i_clk);
            cyc++;
            carry = int'(tick);
            if (rvalid !== 1'b1)
                n += carry;
        end while (rvalid !== 1'b1 && cyc < 20000);
        if (rvalid !== 1'b1)
            bad_count++;
        rdata = rres;
    endtask : wres
    function automatic logic rsv(input logic [3:0] c);
        return c == 4'h6 || c == 4'h7 || c >= 4'hc;
    endfunction : rsv
    function automatic logic [15:0] exp_data(input logic [15:0] r, input int code);
        return r & (16'hffff << (11 - code));
    endfunction : exp_data
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        #6000000;
        bad_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(55905));
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        xfer(0, CFG_ADDR, 0);
        check("setup reset", rd, 32'h00001800);
        xfer(0, 16'hd000, 0);
        check("unmapped", rd, 32'h0);
        for (int c = 0; c < 16; c++) begin
            v = $urandom;
            v = {16'h0000, v[15:11], c[3:0], v[6:2], 2'h0};
            xfer(1, CFG_ADDR, v);
            repeat (2) @(posedge i_clk);
            check("pos sel", psel, v[10:7]);
            check("neg sel", nsel, v[6:3]);
            check("ranges", {ph, nh}, v[12:11]);
            check("clk sel", slow, v[2]);
            check("reserved", resv, rsv(v[10:7]) | rsv(v[6:3]));
            xfer(0, CFG_ADDR, 0);
            check("setup", rd, v);
        end
        // Polled single-result order; two samples so both halves flag.
        xfer(1, EVEN_ADDR, 0);
        xfer(1, OFFS_ADDR, 0);
        xfer(1, GAIN_ADDR, 32'h8000);
        raw <= 16'($urandom);
        xfer(1, CFG_ADDR, 32'h5);
        xfer(1, FLAG_ADDR, 32'h4);
        run <= 1'b1;
        wres(0);
        check("first delay", n > 81 && n < 87, 1);
        check("slow rate", cyc > n * 10 - 11 && cyc < n * 10 + 11, 1);
        check("data", rdata, exp_data(raw, 0));
        check("running", core_en, 1);
        wres(1);
        xfer(0, FLAG_ADDR, 0);
        check("flags", rd, 32'h6);
        for (int k = 0; k < 8; k++) begin
            raw <= 16'($urandom);
            xfer(1, CFG_ADDR, {16'h0000, k[2:0], 13'h0001});
            wres(0);
            check("discard", n, BASE_CLOCKS << (k + 1));
            check("data", rdata, exp_data(raw, k));
            wres(1);
            check("period", n, BASE_CLOCKS << k);
            check("data", rdata, exp_data(raw, k));
        end
        xfer(0, FLAG_ADDR, 0);
        check("no ovf", rd[4], 0);
        for (int s = 0; s < 2; s++) begin
            xfer(1, OFFS_ADDR, s ? 32'h8000 : 32'h7fff);
            raw <= s ? 16'h8000 : 16'h7fff;
            xfer(1, CFG_ADDR, 32'h1);
            wres(0);
            check("clamp", rdata, s ? 16'h8000 : 16'h7fff);
            xfer(0, FLAG_ADDR, 0);
            check("sat", rd[3], 1);
            xfer(1, FLAG_ADDR, 32'h1e);
        end
        // Without this the running conversions keep saturating.
        xfer(1, OFFS_ADDR, 0);
        run <= 1'b0;
        wres(0);
        xfer(1, FLAG_ADDR, 0);
        xfer(0, FLAG_ADDR, 0);
        check("ovf kept", rd[4], 1);
        check("irq off", irq, 0);
        xfer(1, EVEN_ADDR, 32'h8);
        repeat (2) @(posedge i_clk);
        check("irq masked", irq, 0);
        xfer(1, EVEN_ADDR, 32'h10);
        repeat (2) @(posedge i_clk);
        check("irq on", irq, 1);
        wres(0);
        xfer(1, FLAG_ADDR, 32'h10);
        xfer(0, FLAG_ADDR, 0);
        check("ovf clear", rd[4], 0);
        check("irq clear", irq, 0);
        run <= 1'b1;
        xfer(1, FLAG_ADDR, 32'h10);
        wres(0);
        repeat (10) @(posedge i_clk);
        sw <= 1'b1;
        @(posedge i_clk);
        sw <= 1'b0;
        wres(0);
        check("clk switch", n, 2 * BASE_CLOCKS);
        xfer(1, CFG_ADDR, 0);
        repeat (2) @(posedge i_clk);
        check("stopped", core_en, 0);
        n = 0;
        repeat (400) begin
            @(posedge i_clk);
            n += int'(rvalid);
        end
        check("no results", n, 0);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
